// ==== hdl/clock_control_defines.svh ====
// Register offsets, field positions, reset values and bus codes
`ifndef CLOCK_CONTROL_DEFINES_SVH
`define CLOCK_CONTROL_DEFINES_SVH

// Register byte offsets inside the block's window
`define CLK_DIV_ADDR        12'h000
`define MOD_STOP_ADDR       12'h004

// Reset values after power-on reset
`define CLK_DIV_RESET       16'h0000
`define MOD_STOP_RESET      8'h00

// Writable bits; reserved bits read as zero
`define CLK_DIV_WMASK       16'h7FFF
`define MOD_STOP_WMASK      8'hFC

// Divide field positions in the divider control register
`define CORE_DIV_LSB        12
`define BUS_DIV_LSB         9
`define PERIPH_DIV_LSB      6
`define SECOND_TMR_DIV_LSB  3
`define FIRST_TMR_DIV_LSB   0
`define DIV_FIELD_W         3

// Module stop bits occupy bits 7 down to 2
`define STOP_LSB            2
`define STOP_COUNT          6
`define SERIAL_STOP_INDEX   4

// Divide codes with documented ratios
`define DIV_CODE_TIMES_ONE  3'h0
`define DIV_CODE_HALF       3'h1

// AHB-Lite codes
`define HSIZE_WORD          3'h2

`endif

// ==== hdl/clock_control_pkg.sv ====
// Types shared by the clock control block and its ratio dividers
package clock_control_pkg;

   // State of one ratio divider
   typedef struct packed
   {
      logic [2:0] count;
      logic       tick;
   } div_state_t;

   // State of the clock control top
   typedef struct packed
   {
      logic [15:0] clock_frequency_divider_control;
      logic [7:0]  module_clock_stop_control_three;
      logic        dp_valid;
      logic        dp_write;
      logic        dp_word;
      logic [11:0] dp_addr;
      logic [31:0] hrdata;
      logic        hreadyout;
      logic        hresp;
      logic [5:0]  module_clock_enable;
   } ctrl_state_t;

endpackage

// ==== hdl/clk_ratio_tick.sv ====
// Ratio divider: one enable tick every (divide code + 1) input clocks
`timescale 1ns/1ps
module clk_ratio_tick
   import clock_control_pkg::*;
(
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic [2:0] divide_code,
   output logic            tick
);

   div_state_t st;
   div_state_t next_st;

   // Count wraps once it reaches the code, so a new code acts at once
   always_comb
   begin
      next_st = st;
      if (st.count >= divide_code)
      begin
         next_st.count = 3'h0;
      end
      else
      begin
         next_st.count = st.count + 3'h1;
      end
      next_st.tick = (next_st.count == 3'h0);
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st <= '{count: 3'h0, tick: 1'b0};
      end
      else
      begin
         st <= next_st;
      end
   end

   assign tick = st.tick;   // Straight from the flip-flop

   // Ratio one: enable stands high every cycle
   a_ratio_one_high: assert property (@(posedge hclk) disable iff (!hresetn)
      divide_code == 3'h0 |=> tick)
      else $error("ratio one tick missed");

   // Ratio one half: enable toggles each cycle once settled
   a_ratio_half_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
      (divide_code == 3'h1) [*3] |-> tick != $past(tick))
      else $error("half ratio tick not alternating");

endmodule

// ==== hdl/clock_control.sv ====
// Clock control: divide ratios for five clocks and module stop gating
`timescale 1ns/1ps
// Behaviour
// - Core clock enable runs every cycle when its divide code is 000.
// - Bus clock enable runs at half rate when its divide code is 001.
// - Peripheral clock enable runs at half rate for divide code 001.
// - Second timer clock enable runs every cycle for divide code 000.
// - First timer clock enable runs at half rate for divide code 001.
// - A module stop bit at 1, bits 7 to 2, cuts that module's clock.
// - Serial FIFO module keeps its clock while stop bit 6 is 0.
`include "clock_control_defines.svh"
module clock_control
   import clock_control_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   output logic             core_clk_en,
   output logic             bus_clk_en,
   output logic             periph_clk_en,
   output logic             second_timer_clk_en,
   output logic             first_timer_clk_en,
   output logic [5:0]       module_clock_enable
);

   ctrl_state_t st;
   ctrl_state_t next_st;

   logic [4:0]  ticks;
   logic [14:0] div_codes;
   logic        addr_phase;
   logic        wr_div;
   logic        wr_stop;
   logic [31:0] read_mux;

   logic [2:0]  core_clock_divide_field;
   logic [2:0]  bus_clock_divide_field;
   logic [2:0]  peripheral_clock_divide_field;
   logic [2:0]  second_timer_clock_divide_field;
   logic [2:0]  first_timer_clock_divide_field;

   // Named views of the divide fields
   assign core_clock_divide_field =
      st.clock_frequency_divider_control[`CORE_DIV_LSB +: `DIV_FIELD_W];
   assign bus_clock_divide_field =
      st.clock_frequency_divider_control[`BUS_DIV_LSB +: `DIV_FIELD_W];
   assign peripheral_clock_divide_field =
      st.clock_frequency_divider_control[`PERIPH_DIV_LSB +: `DIV_FIELD_W];
   assign second_timer_clock_divide_field =
      st.clock_frequency_divider_control[`SECOND_TMR_DIV_LSB +: `DIV_FIELD_W];
   assign first_timer_clock_divide_field =
      st.clock_frequency_divider_control[`FIRST_TMR_DIV_LSB +: `DIV_FIELD_W];

   // Fields packed low to high: first timer, second timer, periph, bus, core
   assign div_codes = st.clock_frequency_divider_control[14:0];

   // One divider per derived clock, each reading the live register field
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++)
      begin : g_div
         clk_ratio_tick u_div
         (
            .hclk        (hclk),
            .hresetn     (hresetn),
            .divide_code (div_codes[gi*3 +: 3]),
            .tick        (ticks[gi])
         );
      end
   endgenerate

   // Bus decode: a transfer is taken only when the bus is ready
   assign addr_phase = hsel & hready & htrans[1];
   assign wr_div  = st.dp_valid & st.dp_write & st.dp_word &
                    (st.dp_addr == `CLK_DIV_ADDR);
   assign wr_stop = st.dp_valid & st.dp_write & st.dp_word &
                    (st.dp_addr == `MOD_STOP_ADDR);

   // Read data; a write still in its data phase is forwarded
   always_comb
   begin
      read_mux = 32'h0000_0000;
      if (haddr[11:0] == `CLK_DIV_ADDR)
      begin
         read_mux[15:0] = wr_div ? (hwdata[15:0] & `CLK_DIV_WMASK)
                                 : st.clock_frequency_divider_control;
      end
      else if (haddr[11:0] == `MOD_STOP_ADDR)
      begin
         read_mux[7:0] = wr_stop ? (hwdata[7:0] & `MOD_STOP_WMASK)
                                 : st.module_clock_stop_control_three;
      end
   end

   // Next state: bus phases, register writes and module gating
   always_comb
   begin
      next_st = st;
      next_st.hreadyout = 1'b1;   // Zero wait states, never stalls
      next_st.hresp = 1'b0;       // Always OKAY, even unmapped
      if (wr_div)
      begin
         next_st.clock_frequency_divider_control =
            hwdata[15:0] & `CLK_DIV_WMASK;
      end
      if (wr_stop)
      begin
         next_st.module_clock_stop_control_three =
            hwdata[7:0] & `MOD_STOP_WMASK;
      end
      next_st.dp_valid = addr_phase;
      if (addr_phase)
      begin
         next_st.dp_write = hwrite;
         next_st.dp_word = (hsize == `HSIZE_WORD);
         next_st.dp_addr = haddr[11:0];
         next_st.hrdata = hwrite ? 32'h0000_0000 : read_mux;
      end
      // Gated enables follow the peripheral tick one cycle later
      next_st.module_clock_enable = {6{ticks[2]}} &
         ~st.module_clock_stop_control_three[7:`STOP_LSB];
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st <= '{clock_frequency_divider_control: `CLK_DIV_RESET,
                 module_clock_stop_control_three: `MOD_STOP_RESET,
                 dp_valid: 1'b0,
                 dp_write: 1'b0,
                 dp_word: 1'b0,
                 dp_addr: 12'h000,
                 hrdata: 32'h0000_0000,
                 hreadyout: 1'b1,
                 hresp: 1'b0,
                 module_clock_enable: 6'h00};
      end
      else
      begin
         st <= next_st;
      end
   end

   // Outputs straight from flip-flops
   assign hreadyout           = st.hreadyout;
   assign hrdata              = st.hrdata;
   assign hresp               = st.hresp;
   assign module_clock_enable = st.module_clock_enable;
   assign first_timer_clk_en  = ticks[0];
   assign second_timer_clk_en = ticks[1];
   assign periph_clk_en       = ticks[2];
   assign bus_clk_en          = ticks[3];
   assign core_clk_en         = ticks[4];

   // Ratio checks at the top-level enables
   a_core_full_rate: assert property (@(posedge hclk) disable iff (!hresetn)
      core_clock_divide_field == `DIV_CODE_TIMES_ONE |=> core_clk_en)
      else $error("core enable not full rate");

   a_bus_half_rate: assert property (@(posedge hclk) disable iff (!hresetn)
      (bus_clock_divide_field == `DIV_CODE_HALF) [*3]
      |-> bus_clk_en != $past(bus_clk_en))
      else $error("bus enable not half rate");

   a_periph_half_rate: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (peripheral_clock_divide_field == `DIV_CODE_HALF) [*3]
      |-> periph_clk_en ##1 !periph_clk_en or
          !periph_clk_en ##1 periph_clk_en)
      else $error("peripheral enable not half rate");

   a_second_tmr_rate: assert property (@(posedge hclk) disable iff (!hresetn)
      second_timer_clock_divide_field == `DIV_CODE_TIMES_ONE
      |=> second_timer_clk_en)
      else $error("second timer enable not full rate");

   a_first_tmr_rate: assert property (@(posedge hclk) disable iff (!hresetn)
      (first_timer_clock_divide_field == `DIV_CODE_HALF) [*2]
      |=> first_timer_clk_en != $past(first_timer_clk_en))
      else $error("first timer enable not half rate");

   // Each stopped module sees no enable
   generate
      for (gi = 0; gi < `STOP_COUNT; gi++)
      begin : g_stop_chk
         a_stop_cuts_clock: assert property (@(posedge hclk)
            disable iff (!hresetn)
            st.module_clock_stop_control_three[gi + `STOP_LSB]
            |=> !module_clock_enable[gi])
            else $error("stopped module still clocked");
      end
   endgenerate

   a_serial_runs: assert property (@(posedge hclk) disable iff (!hresetn)
      !st.module_clock_stop_control_three[`SERIAL_STOP_INDEX + `STOP_LSB]
      && periph_clk_en |=> module_clock_enable[`SERIAL_STOP_INDEX])
      else $error("serial module lost its clock");

   a_write_applies: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_div |=> st.clock_frequency_divider_control ==
                 ($past(hwdata[15:0]) & `CLK_DIV_WMASK))
      else $error("divider write not applied");

   a_stop_write_acts: assert property (@(posedge hclk)
      disable iff (!hresetn)
      wr_stop && hwdata[`SERIAL_STOP_INDEX + `STOP_LSB]
      |=> ##1 !module_clock_enable[`SERIAL_STOP_INDEX])
      else $error("stop write not acted on");

   // Bus side never stalls and never reports an error
   a_bus_never_waits: assert property (@(posedge hclk) disable iff (!hresetn)
      hreadyout)
      else $error("bus ready dropped");

   a_bus_always_okay: assert property (@(posedge hclk) disable iff (!hresetn)
      !hresp)
      else $error("bus response not okay");

   // Reserved bits are masked on write, so they can never be stored
   a_reserved_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      !st.clock_frequency_divider_control[15] &&
      st.module_clock_stop_control_three[1:0] == 2'h0)
      else $error("reserved bit stored");

   // A read with no write pending returns the held divider value
   a_div_read_back: assert property (@(posedge hclk) disable iff (!hresetn)
      addr_phase && !hwrite && haddr[11:0] == `CLK_DIV_ADDR && !wr_div
      |=> hrdata == {16'h0000, $past(st.clock_frequency_divider_control)})
      else $error("divider read back wrong");

   // A read with no write pending returns the held stop bits
   a_stop_read_back: assert property (@(posedge hclk) disable iff (!hresetn)
      addr_phase && !hwrite && haddr[11:0] == `MOD_STOP_ADDR && !wr_stop
      |=> hrdata == {24'h000000, $past(st.module_clock_stop_control_three)})
      else $error("stop register read back wrong");

   // Main scenarios
   c_div_write: cover property (@(posedge hclk) disable iff (!hresetn)
      wr_div);
   c_stop_write: cover property (@(posedge hclk) disable iff (!hresetn)
      wr_stop);
   c_read_back: cover property (@(posedge hclk) disable iff (!hresetn)
      addr_phase && !hwrite ##1 hrdata != 32'h0000_0000);
   c_serial_gated: cover property (@(posedge hclk) disable iff (!hresetn)
      module_clock_enable[`SERIAL_STOP_INDEX] ##1
      !module_clock_enable[`SERIAL_STOP_INDEX]);

endmodule

// ==== tb/clock_control_bench.sv ====
// Self-checking bench for the clock control block
`timescale 1ns/1ps
module clock_control_bench
   import clock_control_pkg::*;
;
   typedef struct packed
   {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic [31:0] rexp;
   } row_t;

   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic        hresp;
   logic        core_clk_en;
   logic        bus_clk_en;
   logic        periph_clk_en;
   logic        second_timer_clk_en;
   logic        first_timer_clk_en;
   logic [5:0]  module_clock_enable;
   logic [31:0] rd;
   logic [31:0] cnt [11];
   row_t        rows [7];
   int          failures;
   int          checks;
   int          cycles;

   clock_control dut
   (
      .hclk                (hclk),
      .hresetn             (hresetn),
      .hsel                (hsel),
      .haddr               (haddr),
      .htrans              (htrans),
      .hwrite              (hwrite),
      .hsize               (hsize),
      .hwdata              (hwdata),
      .hready              (hreadyout),
      .hreadyout           (hreadyout),
      .hrdata              (hrdata),
      .hresp               (hresp),
      .core_clk_en         (core_clk_en),
      .bus_clk_en          (bus_clk_en),
      .periph_clk_en       (periph_clk_en),
      .second_timer_clk_en (second_timer_clk_en),
      .first_timer_clk_en  (first_timer_clk_en),
      .module_clock_enable (module_clock_enable)
   );

   // 10 MHz clock
   initial
   begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      $display("failures=%0d checks=%0d", failures, checks);
      if (failures == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Wait for hready at a rising edge; outputs read here hold pre-edge values
   task automatic wait_ready();
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      rd = hrdata;
   endtask

   // One single AHB-Lite transfer of size sz; read data lands in rd
   task automatic xfer(input logic [11:0] a, input logic w,
                       input logic [31:0] d, input logic [2:0] sz);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {20'h00000, a};
      hwrite <= w;
      hsize  <= sz;
      wait_ready();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
   endtask

   // Count enable highs over 8 cycles once the new setting has settled
   task automatic check_pat(input logic [31:0] e_core, e_bus, e_per,
                            e_sec, e_first, input logic [5:0] on);
      for (int i = 0; i < 11; i++)
         cnt[i] = 32'h0;
      repeat (4) @(posedge hclk);
      repeat (8)
      begin
         @(negedge hclk);
         cnt[0] = cnt[0] + {31'h0, core_clk_en};
         cnt[1] = cnt[1] + {31'h0, bus_clk_en};
         cnt[2] = cnt[2] + {31'h0, periph_clk_en};
         cnt[3] = cnt[3] + {31'h0, second_timer_clk_en};
         cnt[4] = cnt[4] + {31'h0, first_timer_clk_en};
         for (int i = 0; i < 6; i++)
            cnt[5+i] = cnt[5+i] + {31'h0, module_clock_enable[i]};
      end
      check(cnt[0], e_core);
      check(cnt[1], e_bus);
      check(cnt[2], e_per);
      check(cnt[3], e_sec);
      check(cnt[4], e_first);
      for (int i = 0; i < 6; i++)
         check(cnt[5+i], on[i] ? e_per : 32'h0);
   endtask

   // Hang guard
   always @(posedge hclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         finish_test();
      end
   end

   // Main sequence: table of writes with read-back, then hand tests
   initial
   begin
      hresetn = 1'b0;
      hsel    = 1'b0;
      haddr   = 32'h0;
      htrans  = 2'h0;
      hwrite  = 1'b0;
      hsize   = 3'h2;
      hwdata  = 32'h0;
      rows[0] = '{12'h000, 32'h00000241, 32'h00000241};
      rows[1] = '{12'h004, 32'h000000BF, 32'h000000BC};
      rows[2] = '{12'h000, 32'hFFFFFFFF, 32'h00007FFF};
      rows[3] = '{12'h004, 32'hFFFFFFFF, 32'h000000FC};
      rows[4] = '{12'h008, 32'h12345678, 32'h00000000};
      rows[5] = '{12'h000, 32'h00000000, 32'h00000000};
      rows[6] = '{12'h004, 32'h00000000, 32'h00000000};
      repeat (10) @(posedge hclk);
      #1;
      check({31'h0, hreadyout}, 32'h1);
      check({31'h0, core_clk_en}, 32'h0);
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(12'h000, 1'b0, 32'h0, 3'h2);
      check(rd, 32'h0);
      xfer(12'h004, 1'b0, 32'h0, 3'h2);
      check(rd, 32'h0);
      check_pat(8, 8, 8, 8, 8, 6'h3F);
      for (int r = 0; r < 7; r++)
      begin
         xfer(rows[r].addr, 1'b1, rows[r].wdata, 3'h2);
         xfer(rows[r].addr, 1'b0, 32'h0, 3'h2);
         check(rd, rows[r].rexp);
      end
      // Sample setting: core and second timer full rate, others half
      xfer(12'h000, 1'b1, 32'h00000241, 3'h2);
      check_pat(8, 4, 4, 8, 4, 6'h3F);
      xfer(12'h004, 1'b1, 32'h000000BF, 3'h2);
      check_pat(8, 4, 4, 8, 4, 6'h10);
      // Each stop bit alone gates exactly its own module
      for (int i = 0; i < 6; i++)
      begin
         xfer(12'h004, 1'b1, 32'h4 << i, 3'h2);
         check_pat(8, 4, 4, 8, 4, ~(6'h01 << i));
      end
      // Byte-sized write must leave the divider untouched
      xfer(12'h000, 1'b1, 32'h00000000, 3'h0);
      xfer(12'h000, 1'b0, 32'h0, 3'h2);
      check(rd, 32'h00000241);
      // Reset in mid-run returns the power-on values
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(12'h000, 1'b0, 32'h0, 3'h2);
      check(rd, 32'h0);
      check_pat(8, 8, 8, 8, 8, 6'h3F);
      check({31'h0, hresp}, 32'h0);
      check({31'h0, hreadyout}, 32'h1);
      finish_test();
   end
endmodule
